// *** logic/drive_mode_sequencer.sv ***
// operating-mode sequencer: power stage states, mode start/stop, gear gating, i/o mapping
`timescale 1ns/1ps
`default_nettype none
`include "drive_mode_defines.svh"

module drive_mode_sequencer (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // parameter access port
  input  wire logic [15:0]           param_addr,
  input  wire logic [31:0]           param_wdata,
  input  wire logic                  param_wr,
  input  wire logic                  param_rd,
  output logic      [31:0]           param_rdata,
  output logic                       param_ack,
  output logic                       param_err,
  // digital input pins
  input  wire logic                  digital_input_zero,
  input  wire logic                  digital_input_one,
  input  wire logic                  digital_input_two,
  input  wire logic                  digital_input_three,
  input  wire logic                  digital_input_four,
  input  wire logic                  digital_input_five,
  // i/o reassignment
  input  wire logic                  map_override,
  input  wire logic [17:0]           input_map,
  input  wire logic [14:0]           output_map,
  // mode and gear selection
  input  wire drive_mode_pkg::mode_t mode_select,
  input  wire logic [1:0]            gear_method,
  // internal drive signals
  input  wire logic signed [15:0]    target_torque,
  input  wire logic signed [31:0]    gear_velocity_demand,
  input  wire logic                  offset_move_req,
  input  wire logic                  current_threshold_hit,
  input  wire logic                  motor_standstill,
  input  wire logic                  error_event,
  // status outputs
  output logic                       status_output_zero,
  output logic                       status_output_one,
  output logic                       status_output_two,
  output logic                       status_output_three,
  output logic                       status_output_four,
  // drive controls
  output logic      [3:0]            op_state_num,
  output drive_mode_pkg::mode_t      active_mode,
  output logic signed [15:0]         torque_command,
  output logic signed [31:0]         gear_velocity_out,
  output logic      [31:0]           offset_accel,
  output logic      [31:0]           offset_decel,
  output logic                       offset_move_start,
  output logic                       profile_reconfig_ok,
  output logic                       follow_err_mon_en,
  output logic                       vel_window_mon_en,
  output logic                       vel_limit_req,
  output logic                       cur_limit_req,
  output logic                       halt_req,
  output logic                       mode_switch_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  drive_mode_pkg::op_state_t state;
  drive_mode_pkg::op_state_t next_state;
  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic [5:0]  fn_level;
  logic [2:0]  fn_src [0:5];
  logic [2:0]  out_src [0:4];
  logic [4:0]  out_source;
  logic [4:0]  out_level;
  logic        fault_reset_prev;
  logic        fault_reset_edge;
  logic        error_latched;
  logic [15:0] gear_direction_release;
  logic [31:0] offset_ramp_rate;
  logic [31:0] ramp_applied;
  logic        stage_enabled;
  logic        pos_method;
  logic        vel_method;
  logic        gear_running;
  logic        wr_ramp_ok;
  logic        wr_dir_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds the second only

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= {digital_input_five, digital_input_four, digital_input_three,
                   digital_input_two, digital_input_one, digital_input_zero};
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input and output function routing

  // factory map is identity in every mode; the mode is kept as an argument so
  // a later mode-specific table slots in without touching the routing
  function automatic logic [2:0] default_in_src(input drive_mode_pkg::mode_t m,
                                                input int fn);
    default_in_src = 3'(fn);
    if (m == drive_mode_pkg::mode_none) begin
      default_in_src = 3'(fn);
    end
  endfunction : default_in_src

  genvar gi;
  generate
    // each function picks one synchronised pin
    for (gi = 0; gi < 6; gi++) begin : g_in
      assign fn_src[gi]   = map_override ? input_map[gi*3 +: 3]
                                         : default_in_src(mode_select, gi);
      assign fn_level[gi] = (fn_src[gi] < 3'h6) ? pin_sync[fn_src[gi]] : 1'b0;
    end
    // each status output picks one status source
    for (gi = 0; gi < 5; gi++) begin : g_out
      assign out_src[gi]   = map_override ? output_map[gi*3 +: 3] : 3'(gi);
      assign out_level[gi] = (out_src[gi] < 3'h5) ? out_source[out_src[gi]] : 1'b0;
    end
  endgenerate

  // status sources in factory output order
  always_comb begin
    out_source[0] = (state != drive_mode_pkg::st_fault);
    out_source[1] = (state == drive_mode_pkg::st_enabled);
    out_source[2] = current_threshold_hit;
    out_source[3] = motor_standstill;
    out_source[4] = error_latched;
  end

  // outputs registered so the pins never glitch on a map change
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {status_output_four, status_output_three, status_output_two,
       status_output_one, status_output_zero} <= 5'h00;
    end else begin
      {status_output_four, status_output_three, status_output_two,
       status_output_one, status_output_zero} <= out_level;
    end
  end

  // pass-through function requests
  always_comb begin
    vel_limit_req   = fn_level[`FN_VEL_LIMIT];
    cur_limit_req   = fn_level[`FN_CUR_LIMIT];
    halt_req        = fn_level[`FN_HALT];
    mode_switch_req = fn_level[`FN_MODE_SWITCH];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault latch and edge-triggered fault reset

  assign fault_reset_edge = fn_level[`FN_FAULT_RESET] & ~fault_reset_prev;

  // a new error in the reset cycle wins, so no error slips through unseen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_reset_prev <= 1'b0;
      error_latched    <= 1'b0;
    end else begin
      fault_reset_prev <= fn_level[`FN_FAULT_RESET];
      if (error_event) begin
        error_latched <= 1'b1;
      end else if (fault_reset_edge) begin
        error_latched <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operating state machine

  always_comb begin
    next_state = state;
    case (state)
      drive_mode_pkg::st_ready: begin
        if (error_latched) next_state = drive_mode_pkg::st_fault;
        else if (fn_level[`FN_ENABLE]) next_state = drive_mode_pkg::st_on;
      end
      drive_mode_pkg::st_on: begin
        if (error_latched) next_state = drive_mode_pkg::st_fault;
        else if (fn_level[`FN_ENABLE]) next_state = drive_mode_pkg::st_enabled;
        else next_state = drive_mode_pkg::st_ready;
      end
      drive_mode_pkg::st_enabled: begin
        if (error_latched) next_state = drive_mode_pkg::st_fault;
        else if (!fn_level[`FN_ENABLE]) next_state = drive_mode_pkg::st_ready;
      end
      drive_mode_pkg::st_fault: begin
        if (!error_latched) next_state = drive_mode_pkg::st_ready;
      end
      default: next_state = drive_mode_pkg::st_ready;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= drive_mode_pkg::st_ready;
    end else begin
      state <= next_state;
    end
  end

  assign stage_enabled = (state == drive_mode_pkg::st_enabled);

  // reported state number
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op_state_num <= `STATE_NUM_READY;
    end else begin
      case (next_state)
        drive_mode_pkg::st_on:      op_state_num <= `STATE_NUM_ON;
        drive_mode_pkg::st_enabled: op_state_num <= `STATE_NUM_ENABLED;
        drive_mode_pkg::st_fault:   op_state_num <= `STATE_NUM_FAULT;
        default:                    op_state_num <= `STATE_NUM_READY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode start and stop with the power stage; ramp taken over on enable

  // the host must pick the mode before enabling; later changes wait for the
  // next enable, since the mode is sampled only on that edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_mode  <= drive_mode_pkg::mode_none;
      ramp_applied <= `OFFSET_RAMP_RESET;
    end else if (next_state == drive_mode_pkg::st_enabled && !stage_enabled) begin
      active_mode  <= mode_select;
      ramp_applied <= offset_ramp_rate;
    end else if (next_state != drive_mode_pkg::st_enabled) begin
      active_mode  <= drive_mode_pkg::mode_none;
    end
  end

  assign offset_accel = ramp_applied;
  assign offset_decel = ramp_applied;

  ////////////////////////////////////////////////////////////////////////////////
  // gear method gating

  always_comb begin
    pos_method   = (gear_method == 2'(drive_mode_pkg::gear_pos_immediate)) ||
                   (gear_method == 2'(drive_mode_pkg::gear_pos_compensated));
    vel_method   = (gear_method == 2'(drive_mode_pkg::gear_vel_sync));
    gear_running = (active_mode == drive_mode_pkg::mode_gear);
    profile_reconfig_ok = gear_running & vel_method;
    follow_err_mon_en   = gear_running & pos_method;
    vel_window_mon_en   = gear_running & vel_method;
  end

  // offset move start, the request registered for one cycle and held while it stays high, position methods only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      offset_move_start <= 1'b0;
    end else begin
      offset_move_start <= offset_move_req & gear_running & pos_method;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // motion outputs

  // the lock is combinational on the register so a new release acts at once
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gear_velocity_out <= 32'sh0000_0000;
      torque_command    <= 16'sh0000;
    end else begin
      if (!gear_running) begin
        gear_velocity_out <= 32'sh0000_0000;
      end else if (gear_velocity_demand > 0 && !gear_direction_release[0]) begin
        gear_velocity_out <= 32'sh0000_0000;
      end else if (gear_velocity_demand < 0 && !gear_direction_release[1]) begin
        gear_velocity_out <= 32'sh0000_0000;
      end else begin
        gear_velocity_out <= gear_velocity_demand;
      end
      if (active_mode == drive_mode_pkg::mode_torque) begin
        torque_command <= target_torque;
      end else begin
        torque_command <= 16'sh0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // parameter access

  always_comb begin
    wr_ramp_ok = !stage_enabled &&
                 param_wdata >= `OFFSET_RAMP_MIN && param_wdata <= `OFFSET_RAMP_MAX;
    wr_dir_ok  = param_wdata[15:0] == `DIR_POSITIVE ||
                 param_wdata[15:0] == `DIR_NEGATIVE ||
                 param_wdata[15:0] == `DIR_BOTH;
  end

  // register writes; rejected writes leave the value untouched
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gear_direction_release <= `DIR_RELEASE_RESET;
      offset_ramp_rate       <= `OFFSET_RAMP_RESET;
    end else if (param_wr) begin
      if (param_addr == `OFFSET_RAMP_ADDR && wr_ramp_ok) begin
        offset_ramp_rate <= param_wdata;
      end else if (param_addr == `DIR_RELEASE_ADDR && wr_dir_ok) begin
        gear_direction_release <= param_wdata[15:0];
      end
    end
  end

  // one-cycle answer: ack for accepted, err for rejected or unmapped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      param_ack   <= 1'b0;
      param_err   <= 1'b0;
      param_rdata <= 32'h0000_0000;
    end else begin
      param_ack <= 1'b0;
      param_err <= 1'b0;
      if (param_wr) begin
        if (param_addr == `OFFSET_RAMP_ADDR) begin
          param_ack <= wr_ramp_ok;
          param_err <= !wr_ramp_ok;
        end else if (param_addr == `DIR_RELEASE_ADDR) begin
          param_ack <= wr_dir_ok;
          param_err <= !wr_dir_ok;
        end else begin
          param_err <= 1'b1;
        end
      end else if (param_rd) begin
        if (param_addr == `OFFSET_RAMP_ADDR) begin
          param_rdata <= offset_ramp_rate;
          param_ack   <= 1'b1;
        end else if (param_addr == `DIR_RELEASE_ADDR) begin
          param_rdata <= {16'h0000, gear_direction_release};
          param_ack   <= 1'b1;
        end else begin
          param_rdata <= 32'h0000_0000;
          param_err   <= 1'b1;
        end
      end
    end
  end

endmodule : drive_mode_sequencer
`default_nettype wire

// *** logic/drive_mode_defines.svh ***
// constants for the drive mode sequencer: parameter addresses, resets, field codes
`ifndef DRIVE_MODE_DEFINES_SVH
`define DRIVE_MODE_DEFINES_SVH

// fieldbus parameter addresses
`define DIR_RELEASE_ADDR    16'h260a
`define OFFSET_RAMP_ADDR    16'h270c

// reset values and offset ramp write limits
`define DIR_RELEASE_RESET   16'h0003
`define OFFSET_RAMP_RESET   32'h0000_0258
`define OFFSET_RAMP_MIN     32'h0000_0001
`define OFFSET_RAMP_MAX     32'h7fff_ffff

// direction release codes
`define DIR_POSITIVE        16'h0001
`define DIR_NEGATIVE        16'h0002
`define DIR_BOTH            16'h0003

// operating state numbers reported outward
`define STATE_NUM_READY     4'h4
`define STATE_NUM_ON        4'h5
`define STATE_NUM_ENABLED   4'h6
`define STATE_NUM_FAULT     4'h9

// input function indices (factory order of the six inputs)
`define FN_ENABLE           3'h0
`define FN_FAULT_RESET      3'h1
`define FN_MODE_SWITCH      3'h2
`define FN_VEL_LIMIT        3'h3
`define FN_CUR_LIMIT        3'h4
`define FN_HALT             3'h5

`endif

// *** logic/drive_mode_pkg.sv ***
// types shared by the drive mode sequencer
package drive_mode_pkg;

  // operating state machine, one-hot
  typedef enum logic [3:0] {
    st_ready   = 4'b0001,
    st_on      = 4'b0010,
    st_enabled = 4'b0100,
    st_fault   = 4'b1000
  } op_state_t;

  // operating modes selectable by the host
  typedef enum logic [1:0] {
    mode_none   = 2'h0,
    mode_torque = 2'h1,
    mode_gear   = 2'h2
  } mode_t;

  // gear processing methods
  typedef enum logic [1:0] {
    gear_pos_immediate   = 2'h1,
    gear_pos_compensated = 2'h2,
    gear_vel_sync        = 2'h3
  } gear_method_t;

endpackage : drive_mode_pkg

// *** tb/host_model.sv ***
// host-side model: selects the operating mode and drives enable and fault reset pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                  mclk,
  input  wire logic                  enable_cmd,
  input  wire logic                  reset_cmd,
  input  wire drive_mode_pkg::mode_t mode_cmd,
  output var drive_mode_pkg::mode_t  mode_select,
  output var logic                   digital_input_zero,
  output var logic                   digital_input_one
);
  initial begin
    mode_select = drive_mode_pkg::mode_none;
    digital_input_zero = 1'b0;
    digital_input_one = 1'b0;
  end
  // mode moves only with the stage off; enable waits until the mode has landed
  always @(posedge mclk) begin
    if (!digital_input_zero) begin
      mode_select <= mode_cmd;
    end
    digital_input_zero <= enable_cmd && (mode_select == mode_cmd);
    digital_input_one <= reset_cmd;
  end
endmodule : host_model
`default_nettype wire

// *** tb/drive_mode_checker.sv ***
// concurrent assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "drive_mode_defines.svh"
module drive_mode_checker (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic [15:0]           param_addr,
  input wire logic                  param_wr,
  input wire logic                  param_rd,
  input wire logic                  param_ack,
  input wire logic                  param_err,
  input wire logic [3:0]            op_state_num,
  input wire drive_mode_pkg::mode_t active_mode,
  input wire drive_mode_pkg::mode_t mode_select,
  input wire logic signed [15:0]    target_torque,
  input wire logic signed [15:0]    torque_command,
  input wire logic [31:0]           offset_accel,
  input wire logic [31:0]           offset_decel,
  input wire logic [1:0]            gear_method,
  input wire logic                  follow_err_mon_en,
  input wire logic                  vel_window_mon_en,
  input wire logic                  profile_reconfig_ok,
  input wire logic                  map_override,
  input wire logic                  status_output_one
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_access_answered: assert property ((param_wr || param_rd)
    |=> (param_ack != param_err)) else $error("access not answered by exactly one of ack or err");
  a_ramp_refused: assert property ((param_wr && param_addr == `OFFSET_RAMP_ADDR
    && op_state_num == `STATE_NUM_ENABLED) |=> param_err) else $error("ramp write taken");
  // the applied ramp is never zero, since zero writes are refused
  a_ramp_pair: assert property ((offset_accel == offset_decel)
    && (offset_accel != 32'h0000_0000)) else $error("offset accel and decel differ");
  a_ramp_frozen: assert property ((op_state_num == `STATE_NUM_ENABLED)[*2]
    |-> $stable(offset_accel)) else $error("ramp changed while enabled");
  a_mode_start: assert property ($rose(op_state_num == `STATE_NUM_ENABLED)
    |-> active_mode == $past(mode_select)) else $error("selected mode not started");
  a_mode_end: assert property (op_state_num != `STATE_NUM_ENABLED
    |-> active_mode == drive_mode_pkg::mode_none) else $error("mode runs with stage off");
  a_torque_follow: assert property ((active_mode == drive_mode_pkg::mode_torque)[*2]
    |-> torque_command == $past(target_torque)) else $error("torque command off target");
  a_follow_mon: assert property (follow_err_mon_en ==
    (active_mode == drive_mode_pkg::mode_gear && gear_method inside {2'h1, 2'h2}))
    else $error("following error monitor gating");
  a_vel_window: assert property (vel_window_mon_en ==
    (active_mode == drive_mode_pkg::mode_gear && gear_method == 2'h3))
    else $error("velocity window monitor gating");
  a_reconfig_gate: assert property (profile_reconfig_ok ==
    (active_mode == drive_mode_pkg::mode_gear && gear_method == 2'h3))
    else $error("profile reconfig gating");
  a_active_output: assert property ((!map_override)[*2]
    |-> status_output_one == ($past(op_state_num) == `STATE_NUM_ENABLED))
    else $error("active output wrong");
  // main scenarios reached
  cover property (active_mode == drive_mode_pkg::mode_torque);
  cover property (param_wr && op_state_num == `STATE_NUM_ENABLED ##1 param_err);
  cover property (active_mode == drive_mode_pkg::mode_gear && gear_method == 2'h3);
endmodule : drive_mode_checker
`default_nettype wire

// *** tb/drive_mode_sequencer_tb.sv ***
// self-checking bench for the drive mode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "drive_mode_defines.svh"
module drive_mode_sequencer_tb;
  logic                  mclk = 1'b0, rst_n = 1'b0, param_wr = 1'b0, param_rd = 1'b0;
  logic [15:0]           param_addr = 16'h0000;
  logic [31:0]           param_wdata = 32'h0000_0000, param_rdata, offset_accel, offset_decel;
  logic                  param_ack, param_err, digital_input_zero, digital_input_one;
  logic                  digital_input_two = 1'b0, digital_input_three = 1'b0;
  logic                  digital_input_four = 1'b0, digital_input_five = 1'b0;
  logic                  map_override = 1'b0, enable_cmd = 1'b0, reset_cmd = 1'b0;
  logic [17:0]           input_map = 18'h0_0000;
  logic [14:0]           output_map = 15'h0000;
  drive_mode_pkg::mode_t mode_select, active_mode, mode_cmd = drive_mode_pkg::mode_none;
  logic [1:0]            gear_method = 2'h1;
  logic signed [15:0]    target_torque = 16'sh0123, torque_command;
  logic signed [31:0]    gear_velocity_demand = 32'sh0000_0000, gear_velocity_out;
  logic                  offset_move_req = 1'b0, current_threshold_hit = 1'b0;
  logic                  motor_standstill = 1'b0, error_event = 1'b0;
  logic                  status_output_zero, status_output_one, status_output_two;
  logic                  status_output_three, status_output_four, offset_move_start;
  logic [3:0]            op_state_num;
  logic                  profile_reconfig_ok, follow_err_mon_en, vel_window_mon_en;
  logic                  vel_limit_req, cur_limit_req, halt_req, mode_switch_req;
  int                    errors = 0, checked = 0;

  drive_mode_sequencer dut_u (.*);
  host_model host_u (.mclk(mclk), .enable_cmd(enable_cmd), .reset_cmd(reset_cmd),
    .mode_cmd(mode_cmd), .mode_select(mode_select), .digital_input_zero(digital_input_zero),
    .digital_input_one(digital_input_one));

  // free-running 100 MHz clock
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  // bounded wait; the caller compares afterwards so a hang shows as a mismatch
  task automatic wait_state(input logic [3:0] s);
    for (int i = 0; i < 20 && op_state_num !== s; i++) begin
      settle(1);
    end
  endtask : wait_state

  // one strobe cycle; ack or err is a one-cycle pulse, so look right after the taking edge
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        input logic err_exp, input logic [31:0] rd_exp);
    @(posedge mclk);
    param_wr <= wr;
    param_rd <= !wr;
    param_addr <= a;
    param_wdata <= d;
    @(posedge mclk);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
    #1;
    check("param_err", err_exp, param_err);
    check("param_ack", !err_exp, param_ack);
    if (!wr) check("param_rdata", rd_exp, param_rdata);
  endtask : access

  task automatic set_stage(input drive_mode_pkg::mode_t m, input logic on);
    @(posedge mclk);
    mode_cmd <= m;
    enable_cmd <= on;
    wait_state(on ? `STATE_NUM_ENABLED : `STATE_NUM_READY);
  endtask : set_stage
  ////////////////////////////////////////////////////////////////////////
  task automatic test_ramp;
    access(1'b0, `DIR_RELEASE_ADDR, 32'h0, 1'b0, 32'h0000_0003);
    access(1'b0, `OFFSET_RAMP_ADDR, 32'h0, 1'b0, 32'h0000_0258);
    access(1'b0, 16'h1234, 32'h0, 1'b1, 32'h0000_0000);
    access(1'b1, `OFFSET_RAMP_ADDR, 32'h0000_03e8, 1'b0, 32'h0);
    access(1'b1, `OFFSET_RAMP_ADDR, 32'h0000_0000, 1'b1, 32'h0);
    access(1'b1, `OFFSET_RAMP_ADDR, 32'h8000_0000, 1'b1, 32'h0);
    access(1'b0, `OFFSET_RAMP_ADDR, 32'h0, 1'b0, 32'h0000_03e8);
    check("offset_accel", 32'h0000_0258, offset_accel);
    set_stage(drive_mode_pkg::mode_torque, 1'b1);
    check("active_mode", drive_mode_pkg::mode_torque, active_mode);
    check("offset_decel", 32'h0000_03e8, offset_decel);
    settle(2);
    check("torque_command", 32'h0000_0123, torque_command);
    check("status_output_one", 1'b1, status_output_one);
    check("status_output_zero", 1'b1, status_output_zero);
    access(1'b1, `OFFSET_RAMP_ADDR, 32'h0000_0005, 1'b1, 32'h0);
    set_stage(drive_mode_pkg::mode_torque, 1'b0);
    check("active_mode", drive_mode_pkg::mode_none, active_mode);
    settle(2);
    check("torque_command", 32'h0, torque_command);
    $display("test ramp and torque done");
  endtask : test_ramp

  task automatic test_gear;
    set_stage(drive_mode_pkg::mode_gear, 1'b1);
    for (int m = 1; m <= 3; m++) begin
      @(posedge mclk);
      gear_method <= m[1:0];
      offset_move_req <= 1'b1;
      settle(2);
      check("follow_err_mon_en", m != 3, follow_err_mon_en);
      check("vel_window_mon_en", m == 3, vel_window_mon_en);
      check("profile_reconfig_ok", m == 3, profile_reconfig_ok);
      check("offset_move_start", m != 3, offset_move_start);
      @(posedge mclk);
      offset_move_req <= 1'b0;
      settle(1);
    end
    // each release code, then a positive and a negative demand
    for (int d = 1; d <= 3; d++) begin
      access(1'b1, `DIR_RELEASE_ADDR, 32'(d), 1'b0, 32'h0);
      for (int s = 0; s < 2; s++) begin
        @(posedge mclk);
        gear_velocity_demand <= s ? 32'shffff_ff9c : 32'sh0000_0064;
        settle(2);
        check("gear_velocity_out", d[s] ? (s ? 32'hffff_ff9c : 32'h64) : 32'h0,
              gear_velocity_out);
      end
    end
    access(1'b1, `DIR_RELEASE_ADDR, 32'h0, 1'b1, 32'h0);
    access(1'b0, `DIR_RELEASE_ADDR, 32'h0, 1'b0, 32'h0000_0003);
    set_stage(drive_mode_pkg::mode_gear, 1'b0);
    check("op_state_num", `STATE_NUM_READY, op_state_num);
    $display("test gear done");
  endtask : test_gear

  task automatic test_fault;
    @(posedge mclk);
    error_event <= 1'b1;
    @(posedge mclk);
    error_event <= 1'b0;
    wait_state(`STATE_NUM_FAULT);
    settle(1);
    check("status_output_zero", 1'b0, status_output_zero);
    check("status_output_four", 1'b1, status_output_four);
    @(posedge mclk);
    reset_cmd <= 1'b1;
    wait_state(`STATE_NUM_READY);
    check("op_state_num", `STATE_NUM_READY, op_state_num);
    // a held reset input must not clear a second error
    @(posedge mclk);
    error_event <= 1'b1;
    @(posedge mclk);
    error_event <= 1'b0;
    settle(6);
    check("op_state_num", `STATE_NUM_FAULT, op_state_num);
    @(posedge mclk);
    reset_cmd <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_cmd <= 1'b1;
    wait_state(`STATE_NUM_READY);
    @(posedge mclk);
    reset_cmd <= 1'b0;
    settle(2);
    check("status_output_zero", 1'b1, status_output_zero);
    check("status_output_four", 1'b0, status_output_four);
    $display("test fault done");
  endtask : test_fault

  task automatic test_io;
    @(posedge mclk);
    digital_input_two <= 1'b1;
    digital_input_three <= 1'b1;
    digital_input_four <= 1'b1;
    current_threshold_hit <= 1'b1;
    motor_standstill <= 1'b1;
    settle(4);
    check("mode_switch_req", 1'b1, mode_switch_req);
    check("vel_limit_req", 1'b1, vel_limit_req);
    check("cur_limit_req", 1'b1, cur_limit_req);
    check("halt_req", 1'b0, halt_req);
    check("status_output_two", 1'b1, status_output_two);
    check("status_output_three", 1'b1, status_output_three);
    // reassigned: halt taken from pin four, output four shows the current threshold
    @(posedge mclk);
    map_override <= 1'b1;
    input_map <= 18'h2_4688;
    output_map <= 15'h2688;
    settle(2);
    check("halt_req", 1'b1, halt_req);
    check("status_output_four", 1'b1, status_output_four);
    @(posedge mclk);
    map_override <= 1'b0;
    $display("test io map done");
  endtask : test_io

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // main sequence after 20 cycles of reset
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    test_ramp;
    test_gear;
    test_fault;
    test_io;
    complete_run;
  end

  // watchdog, well beyond the roughly 150 cycles the tests take
  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    complete_run;
  end
endmodule : drive_mode_sequencer_tb

bind drive_mode_sequencer drive_mode_checker chk_u (.*);
`default_nettype wire
